// ---- src/gcn_change.sv ----
// Change-of-state detector comparing each input with its last captured level
`timescale 1ns/1ps
module gcn_change #(
    parameter int N = 24
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic [N-1:0] level, // Synchronised input levels
    input wire logic [N-1:0] enable, // Per-input selection
    output logic changed // One-cycle pulse on any enabled change
);
    logic [N-1:0] prev;
    logic primed;
    logic [N-1:0] diff;

    // Mismatch against the captured level, gated by selection
    assign diff = (level ^ prev) & enable;

    // First cycle after reset only captures, so reset values raise nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
            primed <= 1'b0;
            changed <= 1'b0;
        end else begin
            prev <= level;
            primed <= 1'b1;
            changed <= primed & (|diff);
        end
    end
endmodule

// ---- src/gcn_pkg.sv ----
// Package with register map, field positions and reset values of the port block
package gcn_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_DIR = 8'h00;
    localparam logic [7:0] OFF_LATCH = 8'h04;
    localparam logic [7:0] OFF_PORT = 8'h08;
    localparam logic [7:0] OFF_ODC = 8'h0c;
    localparam logic [7:0] OFF_ACFG_LO1 = 8'h10;
    localparam logic [7:0] OFF_ACFG_LO2 = 8'h14;
    localparam logic [7:0] OFF_CNEN_LO = 8'h18;
    localparam logic [7:0] OFF_CNEN_HI = 8'h1c;
    localparam logic [7:0] OFF_PUEN_LO = 8'h20;
    localparam logic [7:0] OFF_PUEN_HI = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    localparam logic [7:0] OFF_PWRCTL = 8'h2c;

    // Status and power control field positions
    localparam int STAT_CN_FLAG = 0;
    localparam int STAT_SLEEP = 1;
    localparam int PWR_SLEEP = 0;

    // Width of the low change-notify enable and pull-up words
    localparam int CN_LO_W = 16;
    // Largest number of change-notify inputs
    localparam int CN_MAX = 24;
    // Largest port width served by one 32-bit register
    localparam int PW_MAX = 32;

    // Reset values
    localparam logic [31:0] DIR_RST = 32'hffff_ffff;
    localparam logic [31:0] LATCH_RST = 32'h0000_0000;
    localparam logic [31:0] ODC_RST = 32'h0000_0000;
    localparam logic [31:0] ACFG_RST = 32'h0000_0000;
    localparam logic [31:0] CNEN_RST = 32'h0000_0000;
    localparam logic [31:0] PUEN_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ---- src/gcn_sync.sv ----
// Three-flop synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module gcn_sync #(
    parameter int W = 16
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic [W-1:0] async_in, // Level from outside the clock domain
    output logic [W-1:0] sync_out // Filtered, synchronised level
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] agree;

    // Per-bit agreement of the two later stages; first stage feeds only stage2
    assign agree = ~(stage2 ^ stage3);

    // Shift chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Update only agreeing bits, so a one-cycle glitch is not taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= '0;
        end else begin
            sync_out <= (agree & stage3) | (~agree & sync_out);
        end
    end
endmodule

// ---- src/gcn_top.sv ----
// Digital I/O port with open-drain, analog select, change notify and pull-ups
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module gcn_top #(
    parameter int PW = 16, // Port width in pins
    parameter int CN_N = 24, // Number of change-notify inputs
    parameter logic [PW-1:0] ANALOG_PINS = '1 // Pins with an analog function
) (
    input wire logic pclk, // System clock, 200 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [PW-1:0] pad_in, // Pin levels from the pads
    output logic [PW-1:0] pad_out, // Pin drive levels
    output logic [PW-1:0] pad_oe, // Pin drive enables, high drives
    output logic [PW-1:0] pad_ie, // Digital input buffer enables
    output logic [PW-1:0] pad_analog, // Pin routed to the converters
    input wire logic [CN_N-1:0] cn_in, // Change-notify pin levels
    output logic [CN_N-1:0] cn_pullup, // Weak pull-up enables
    output logic cn_irq, // Change interrupt request, level
    input wire logic ext_wake, // Other enabled interrupt pending
    output logic sleeping, // Block reports sleep state
    output logic wake_req // Wake request to the clock control
);
    localparam int CN_HI_W = CN_N - gcn_pkg::CN_LO_W;

    // Widths the register words cannot serve are refused
    if (PW < 1 || PW > gcn_pkg::PW_MAX) begin : g_bad_pw
        $error("port width out of range");
    end
    if (CN_N <= gcn_pkg::CN_LO_W || CN_N > gcn_pkg::CN_MAX) begin : g_bad_cn
        $error("change input count out of range");
    end

    // Address match, shared by write strobes and read selection
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // Analog when cleared in either converter config and analog-capable
    function automatic logic [PW-1:0] analog_of(input logic [PW-1:0] cfg1,
                                                input logic [PW-1:0] cfg2);
        analog_of = ~(cfg1 & cfg2) & ANALOG_PINS;
    endfunction

    // Software-visible state
    logic [PW-1:0] pin_direction;
    logic [PW-1:0] output_latch;
    logic [PW-1:0] open_drain_ctrl;
    logic [PW-1:0] analog_cfg_low1;
    logic [PW-1:0] analog_cfg_low2;
    logic [CN_N-1:0] change_irq_enable;
    logic [CN_N-1:0] pullup_enable;
    logic cn_flag;
    logic sleep_state;

    // Synchronised pin levels
    logic [PW-1:0] pad_sync;
    logic [CN_N-1:0] cn_sync;
    logic cn_event;

    // Bus phase decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable & pready;
    wire wr_ph = access_ph & pwrite;

    // Mapped address check
    wire addr_ok = hit(paddr, gcn_pkg::OFF_DIR) | hit(paddr, gcn_pkg::OFF_LATCH)
                 | hit(paddr, gcn_pkg::OFF_PORT) | hit(paddr, gcn_pkg::OFF_ODC)
                 | hit(paddr, gcn_pkg::OFF_ACFG_LO1) | hit(paddr, gcn_pkg::OFF_ACFG_LO2)
                 | hit(paddr, gcn_pkg::OFF_CNEN_LO) | hit(paddr, gcn_pkg::OFF_CNEN_HI)
                 | hit(paddr, gcn_pkg::OFF_PUEN_LO) | hit(paddr, gcn_pkg::OFF_PUEN_HI)
                 | hit(paddr, gcn_pkg::OFF_STATUS) | hit(paddr, gcn_pkg::OFF_PWRCTL);

    // Write strobes; unmapped writes touch nothing
    wire we_dir = wr_ph & hit(paddr, gcn_pkg::OFF_DIR);
    wire we_latch = wr_ph & (hit(paddr, gcn_pkg::OFF_LATCH) | hit(paddr, gcn_pkg::OFF_PORT));
    wire we_odc = wr_ph & hit(paddr, gcn_pkg::OFF_ODC);
    wire we_acfg1 = wr_ph & hit(paddr, gcn_pkg::OFF_ACFG_LO1);
    wire we_acfg2 = wr_ph & hit(paddr, gcn_pkg::OFF_ACFG_LO2);
    wire we_cnen_lo = wr_ph & hit(paddr, gcn_pkg::OFF_CNEN_LO);
    wire we_cnen_hi = wr_ph & hit(paddr, gcn_pkg::OFF_CNEN_HI);
    wire we_puen_lo = wr_ph & hit(paddr, gcn_pkg::OFF_PUEN_LO);
    wire we_puen_hi = wr_ph & hit(paddr, gcn_pkg::OFF_PUEN_HI);
    wire we_status = wr_ph & hit(paddr, gcn_pkg::OFF_STATUS);
    wire we_pwrctl = wr_ph & hit(paddr, gcn_pkg::OFF_PWRCTL);

    // Analog decode from both converter configs
    wire [PW-1:0] analog_now = analog_of(analog_cfg_low1, analog_cfg_low2);

    // Port read value masks analog pins to zero
    wire [PW-1:0] port_read = pad_sync & ~analog_now;

    // Read words, narrow data sits low with zero above
    wire [31:0] rd_dir = {{(32-PW){1'b0}}, pin_direction};
    wire [31:0] rd_latch = {{(32-PW){1'b0}}, output_latch};
    wire [31:0] rd_port = {{(32-PW){1'b0}}, port_read};
    wire [31:0] rd_odc = {{(32-PW){1'b0}}, open_drain_ctrl};
    wire [31:0] rd_acfg1 = {{(32-PW){1'b0}}, analog_cfg_low1};
    wire [31:0] rd_acfg2 = {{(32-PW){1'b0}}, analog_cfg_low2};
    wire [31:0] rd_cnen_lo = {16'h0000, change_irq_enable[gcn_pkg::CN_LO_W-1:0]};
    wire [31:0] rd_cnen_hi = {{(32-CN_HI_W){1'b0}}, change_irq_enable[CN_N-1:gcn_pkg::CN_LO_W]};
    wire [31:0] rd_puen_lo = {16'h0000, pullup_enable[gcn_pkg::CN_LO_W-1:0]};
    wire [31:0] rd_puen_hi = {{(32-CN_HI_W){1'b0}}, pullup_enable[CN_N-1:gcn_pkg::CN_LO_W]};
    wire [31:0] rd_status = {30'h0, sleep_state, cn_flag};

    // Read selection
    wire [31:0] next_prdata =
        hit(paddr, gcn_pkg::OFF_DIR) ? rd_dir :
        hit(paddr, gcn_pkg::OFF_LATCH) ? rd_latch :
        hit(paddr, gcn_pkg::OFF_PORT) ? rd_port :
        hit(paddr, gcn_pkg::OFF_ODC) ? rd_odc :
        hit(paddr, gcn_pkg::OFF_ACFG_LO1) ? rd_acfg1 :
        hit(paddr, gcn_pkg::OFF_ACFG_LO2) ? rd_acfg2 :
        hit(paddr, gcn_pkg::OFF_CNEN_LO) ? rd_cnen_lo :
        hit(paddr, gcn_pkg::OFF_CNEN_HI) ? rd_cnen_hi :
        hit(paddr, gcn_pkg::OFF_PUEN_LO) ? rd_puen_lo :
        hit(paddr, gcn_pkg::OFF_PUEN_HI) ? rd_puen_hi :
        hit(paddr, gcn_pkg::OFF_STATUS) ? rd_status :
        gcn_pkg::ZERO_WORD;

    // APB answer: ready one cycle after setup, so each access has no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= gcn_pkg::ZERO_WORD;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~addr_ok;
            prdata <= (setup_ph & ~pwrite) ? next_prdata : gcn_pkg::ZERO_WORD;
        end
    end

    // Pin control registers; direction resets to input for safety
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction <= gcn_pkg::DIR_RST[PW-1:0];
            output_latch <= gcn_pkg::LATCH_RST[PW-1:0];
            open_drain_ctrl <= gcn_pkg::ODC_RST[PW-1:0];
        end else begin
            if (we_dir) begin
                pin_direction <= pwdata[PW-1:0];
            end
            if (we_latch) begin
                output_latch <= pwdata[PW-1:0];
            end
            if (we_odc) begin
                open_drain_ctrl <= pwdata[PW-1:0];
            end
        end
    end

    // Converter pin configs come up cleared, so analog pins start analog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_cfg_low1 <= gcn_pkg::ACFG_RST[PW-1:0];
            analog_cfg_low2 <= gcn_pkg::ACFG_RST[PW-1:0];
        end else begin
            if (we_acfg1) begin
                analog_cfg_low1 <= pwdata[PW-1:0];
            end
            if (we_acfg2) begin
                analog_cfg_low2 <= pwdata[PW-1:0];
            end
        end
    end

    // Change enables and pull-ups, split across low and high words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_irq_enable <= gcn_pkg::CNEN_RST[CN_N-1:0];
            pullup_enable <= gcn_pkg::PUEN_RST[CN_N-1:0];
        end else begin
            if (we_cnen_lo) begin
                change_irq_enable[gcn_pkg::CN_LO_W-1:0] <= pwdata[gcn_pkg::CN_LO_W-1:0];
            end
            if (we_cnen_hi) begin
                change_irq_enable[CN_N-1:gcn_pkg::CN_LO_W] <= pwdata[CN_HI_W-1:0];
            end
            if (we_puen_lo) begin
                pullup_enable[gcn_pkg::CN_LO_W-1:0] <= pwdata[gcn_pkg::CN_LO_W-1:0];
            end
            if (we_puen_hi) begin
                pullup_enable[CN_N-1:gcn_pkg::CN_LO_W] <= pwdata[CN_HI_W-1:0];
            end
        end
    end

    // Pin synchronisers; the port read lags pin changes, which software covers
    gcn_sync #(
        .W(PW)
    ) u_pad_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    gcn_sync #(
        .W(CN_N)
    ) u_cn_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cn_in),
        .sync_out(cn_sync)
    );

    // Detector runs on the always-on clock, unaffected by the sleep state
    gcn_change #(
        .N(CN_N)
    ) u_change (
        .pclk(pclk),
        .presetn(presetn),
        .level(cn_sync),
        .enable(change_irq_enable),
        .changed(cn_event)
    );

    // Sticky change flag; a new event wins over a clear in the same cycle
    wire cn_clear = we_status & pwdata[gcn_pkg::STAT_CN_FLAG];
    wire next_cn_flag = cn_event | (cn_flag & ~cn_clear);

    // Sleep entered by software, left on any enabled interrupt
    wire wake_cause = next_cn_flag | ext_wake;
    wire sleep_enter = we_pwrctl & pwdata[gcn_pkg::PWR_SLEEP];
    wire next_sleep = ~wake_cause & (sleep_enter | sleep_state);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cn_flag <= 1'b0;
            sleep_state <= 1'b0;
        end else begin
            cn_flag <= next_cn_flag;
            sleep_state <= next_sleep;
        end
    end

    // Pin drive: open-drain releases for high, push-pull drives both levels
    wire [PW-1:0] out_en = ~pin_direction;
    wire [PW-1:0] next_pad_out = output_latch & ~open_drain_ctrl;
    wire [PW-1:0] next_pad_oe = out_en & (~open_drain_ctrl | ~output_latch);

    // Analog pins keep the output driver, so an output level can be converted
    wire [PW-1:0] next_pad_ie = ~analog_now;

    // Registered outputs toward pads, interrupt and clock control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_ie <= '0;
            pad_analog <= '0;
            cn_pullup <= '0;
            cn_irq <= 1'b0;
            sleeping <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            pad_ie <= next_pad_ie;
            pad_analog <= analog_now;
            cn_pullup <= pullup_enable;
            cn_irq <= next_cn_flag;
            sleeping <= next_sleep;
            wake_req <= sleep_state & wake_cause;
        end
    end
endmodule

// ---- tb/gcn_pin_model.sv ----
// Model of the board around the port pins and change-notify inputs
`timescale 1ns/1ps
module gcn_pin_model #(
    parameter int PW = 16, // Port width
    parameter int CN_N = 24 // Change inputs
) (
    input wire logic pclk, // Clock for the float pattern
    input wire logic [PW-1:0] pad_out, // Device drive levels
    input wire logic [PW-1:0] pad_oe, // Device drive enables
    input wire logic [PW-1:0] drv_en, // Board drives the pad
    input wire logic [PW-1:0] drv_lvl, // Board drive level
    input wire logic [CN_N-1:0] cn_pullup, // Device weak pull-ups
    input wire logic [CN_N-1:0] cn_drv_en, // Board drives the change pin
    input wire logic [CN_N-1:0] cn_drv, // Board change pin level
    output logic [PW-1:0] pad_in, // Resolved pad levels
    output logic [CN_N-1:0] cn_in // Resolved change pin levels
);
    logic flt = 1'b0;

    // Undriven, un-pulled change pins wander so a stale level never looks valid
    always @(posedge pclk) begin
        flt <= ~flt;
    end

    // Released pads sit on the external resistor used with open drain
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv_lvl) | (~pad_oe & ~drv_en);
    // Weak pull-up holds a released change pin high
    assign cn_in = (cn_drv_en & cn_drv) | (~cn_drv_en & (cn_pullup | {CN_N{flt}}));
endmodule

// ---- tb/gcn_top_props.sv ----
// Assertion checker for the port block, bound to its top module
`timescale 1ns/1ps
module gcn_top_props #(
    parameter int PW = 16, // Port width
    parameter int CN_N = 24, // Change inputs
    parameter logic [PW-1:0] ANALOG_PINS = '1 // Analog-capable pins
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // Bus select
    input wire logic penable, // Bus access phase
    input wire logic pwrite, // Bus direction
    input wire logic [7:0] paddr, // Bus address
    input wire logic [31:0] pwdata, // Bus write data
    input wire logic [31:0] prdata, // Bus read data
    input wire logic pready, // Bus ready
    input wire logic [PW-1:0] pad_out, // Pin drive levels
    input wire logic [PW-1:0] pad_oe, // Pin drive enables
    input wire logic [PW-1:0] pad_ie, // Input buffer enables
    input wire logic [PW-1:0] pad_analog, // Analog pins
    input wire logic [CN_N-1:0] cn_in, // Change pin levels
    input wire logic [CN_N-1:0] cn_pullup, // Pull-up enables
    input wire logic cn_irq, // Change request
    input wire logic ext_wake, // Other interrupt pending
    input wire logic sleeping, // Sleep state
    input wire logic wake_req // Wake request
);
    logic [31:0] sh [0:15];
    logic [3:0] widx;
    logic [1:0] age;
    logic wr, clr, live;
    logic [PW-1:0] exp_oe, exp_out, exp_an;
    logic [CN_N-1:0] en_mask, exp_pu;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the writable registers; port writes land in the latch (index 1)
    assign wr = psel && penable && pready && pwrite && paddr[7:6] == 2'h0;
    assign clr = wr && paddr == gcn_pkg::OFF_STATUS && pwdata[0];
    assign widx = (paddr == gcn_pkg::OFF_PORT) ? 4'h1 : paddr[5:2];
    assign live = age == 2'h3;
    assign exp_oe = ~sh[0][PW-1:0] & ~(sh[3][PW-1:0] & sh[1][PW-1:0]);
    assign exp_out = sh[1][PW-1:0] & ~sh[3][PW-1:0];
    assign exp_an = ANALOG_PINS & ~(sh[4][PW-1:0] & sh[5][PW-1:0]);
    assign en_mask = CN_N'({sh[7][7:0], sh[6][15:0]});
    assign exp_pu = CN_N'({sh[9][7:0], sh[8][15:0]});

    // Shadow update at the edge where the write takes effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) sh[i] <= (i == 0) ? gcn_pkg::DIR_RST : '0;
        end else if (wr) begin
            sh[widx] <= pwdata;
        end
    end

    // Outputs settle a few edges after reset, so checks wait for that
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 2'h0;
        end else if (!live) begin
            age <= age + 2'h1;
        end
    end

    AST_OD_DRIVE: assert property (live && $stable(exp_oe) && $stable(exp_out) |->
        pad_oe == exp_oe && pad_out == exp_out) else $error("pin drive wrong");
    AST_ANALOG_SEL: assert property (live && $stable(exp_an) |-> pad_analog == exp_an)
        else $error("analog selection wrong");
    AST_IE_OFF: assert property ((pad_ie & pad_analog) == '0)
        else $error("input buffer on for analog pin");
    AST_PORT_ZERO: assert property (psel && penable && pready && !pwrite &&
        paddr == gcn_pkg::OFF_PORT |-> (prdata[PW-1:0] & pad_analog) == '0)
        else $error("analog pin read not zero");
    AST_PULLUP: assert property (live && $stable(exp_pu) |-> cn_pullup == exp_pu)
        else $error("pull-up enables wrong");
    AST_STICKY: assert property (live && cn_irq && !clr && !$past(clr) |=> cn_irq)
        else $error("change flag dropped without clear");
    AST_NEEDS_EN: assert property (live && $rose(cn_irq) |-> en_mask != '0)
        else $error("change request with no input enabled");
    AST_CHANGE: assert property (live && ((cn_in ^ $past(cn_in)) & en_mask) != '0
        |-> ##[1:10] cn_irq) else $error("enabled change not reported");
    AST_WAKE: assert property (live && sleeping && (cn_irq || ext_wake) |-> ##[1:3] !sleeping)
        else $error("no wake from sleep");
    AST_WAKE_REQ: assert property (live && sleeping && (cn_irq || ext_wake) |-> ##[0:2] wake_req)
        else $error("no wake request");

    cover property (live && $rose(cn_irq));
    cover property ($fell(sleeping));
    cover property (pready && paddr == gcn_pkg::OFF_PORT && pad_analog != '0);
endmodule

bind gcn_top gcn_top_props #(.PW(PW), .CN_N(CN_N), .ANALOG_PINS(ANALOG_PINS)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_ie(pad_ie), .pad_analog(pad_analog), .cn_in(cn_in),
    .cn_pullup(cn_pullup), .cn_irq(cn_irq), .ext_wake(ext_wake), .sleeping(sleeping),
    .wake_req(wake_req));

// ---- tb/testbench.sv ----
// Self-checking bench for the port block with change notification
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_wake = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic pready, pslverr, cn_irq, sleeping, wake_req, err;
    logic [15:0] pad_in, pad_out, pad_oe, pad_ie, pad_analog;
    logic [15:0] drv_en = 16'hffff, drv_lvl = 16'hffff;
    logic [23:0] cn_in, cn_pullup, cn_drv = 24'h000000, cn_drv_en = 24'hffffff;
    int miscompares = 0;
    int check_count = 0;

    gcn_top #(.PW(16), .CN_N(24), .ANALOG_PINS(16'h00ff)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
        .pad_analog(pad_analog), .cn_in(cn_in), .cn_pullup(cn_pullup), .cn_irq(cn_irq),
        .ext_wake(ext_wake), .sleeping(sleeping), .wake_req(wake_req));

    gcn_pin_model #(.PW(16), .CN_N(24)) u_pins (
        .pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .drv_en(drv_en), .drv_lvl(drv_lvl),
        .cn_pullup(cn_pullup), .cn_drv_en(cn_drv_en), .cn_drv(cn_drv), .pad_in(pad_in),
        .cn_in(cn_in));

    always #2.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One bus transfer; waits for ready with a bounded count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits out a sleep; notes whether a wake request was seen
    task automatic wait_wake(output logic w);
        int n;
        n = 0;
        w = 1'b0;
        while (sleeping !== 1'b0 && n < 20) begin
            @(posedge pclk);
            w |= (wake_req === 1'b1);
            n++;
        end
        repeat (2) @(posedge pclk) w |= (wake_req === 1'b1);
    endtask

    task automatic t_reset();
        chk(pad_analog, 16'h00ff);
        apb(1'b0, gcn_pkg::OFF_ACFG_LO1, 32'h0);
        chk(rdata, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0);
        chk({rdata[30:0], err}, 32'h0000_0001);
        $display("Reset test done");
    endtask

    // Analog pins stay inputs here, so nothing digital is converted
    task automatic t_analog();
        apb(1'b0, gcn_pkg::OFF_PORT, 32'h0);
        chk(rdata, 32'h0000_ff00);
        apb(1'b1, gcn_pkg::OFF_ACFG_LO1, 32'h0000_ffff);
        apb(1'b1, gcn_pkg::OFF_ACFG_LO2, 32'h0000_00f0);
        repeat (6) @(posedge pclk);
        chk(pad_analog, 16'h000f);
        chk(pad_ie, 16'hfff0);
        apb(1'b0, gcn_pkg::OFF_PORT, 32'h0);
        chk(rdata, 32'h0000_fff0);
        apb(1'b1, gcn_pkg::OFF_ACFG_LO2, 32'h0000_ffff);
        repeat (6) @(posedge pclk);
        apb(1'b0, gcn_pkg::OFF_PORT, 32'h0);
        chk(rdata, 32'h0000_ffff);
        $display("Analog test done");
    endtask

    // Open-drain then push-pull drive on output pins; reads wait after writes
    task automatic t_drive();
        drv_en <= 16'h0000;
        apb(1'b1, gcn_pkg::OFF_LATCH, 32'h0000_00a5);
        apb(1'b1, gcn_pkg::OFF_ODC, 32'h0000_000f);
        apb(1'b1, gcn_pkg::OFF_DIR, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk(pad_out, 16'h00a0);
        chk(pad_oe, 16'hfffa);
        repeat (6) @(posedge pclk);
        apb(1'b0, gcn_pkg::OFF_PORT, 32'h0);
        chk(rdata, 32'h0000_00a5);
        apb(1'b1, gcn_pkg::OFF_ODC, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk({pad_oe, pad_out}, 32'hffff_00a5);
        apb(1'b1, gcn_pkg::OFF_DIR, 32'h0000_ffff);
        drv_en <= 16'hffff;
        $display("Drive test done");
    endtask

    task automatic t_change();
        apb(1'b1, gcn_pkg::OFF_CNEN_LO, 32'h0000_0001);
        apb(1'b1, gcn_pkg::OFF_CNEN_HI, 32'h0000_0080);
        cn_drv[5] <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(cn_irq, 1'b0);
        cn_drv[23] <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(cn_irq, 1'b1);
        apb(1'b0, gcn_pkg::OFF_STATUS, 32'h0);
        chk(rdata & 32'h1, 32'h1);
        repeat (4) @(posedge pclk);
        chk(cn_irq, 1'b1);
        apb(1'b1, gcn_pkg::OFF_STATUS, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(cn_irq, 1'b0);
        apb(1'b1, gcn_pkg::OFF_PUEN_LO, 32'h0000_00ff);
        apb(1'b1, gcn_pkg::OFF_PUEN_HI, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(cn_pullup, 24'h0100ff);
        apb(1'b0, gcn_pkg::OFF_CNEN_LO, 32'h0);
        chk(rdata, 32'h0000_0001);
        $display("Change test done");
    endtask

    task automatic t_sleep();
        logic w;
        apb(1'b1, gcn_pkg::OFF_PWRCTL, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(sleeping, 1'b1);
        cn_drv[23] <= 1'b0;
        wait_wake(w);
        chk({cn_irq, w, sleeping}, 3'b110);
        apb(1'b1, gcn_pkg::OFF_STATUS, 32'h0000_0001);
        apb(1'b1, gcn_pkg::OFF_PWRCTL, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        ext_wake <= 1'b1;
        wait_wake(w);
        chk({w, sleeping}, 2'b10);
        ext_wake <= 1'b0;
        $display("Sleep test done");
    endtask

    // Watchdog far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_reset();
        t_analog();
        t_drive();
        t_change();
        t_sleep();
        test_done();
    end
endmodule
